// ==== rtl/rsu_consts.vh ====
// Constants for the rotate and shift unit
`ifndef RSU_CONSTS_VH
`define RSU_CONSTS_VH
// ----------------------------------------
// Prefix and operation byte encodings
// ----------------------------------------
`define RSU_PFX_CB        8'hCB
`define RSU_PFX_FIRST_IX  8'hDD
`define RSU_PFX_SECOND_IX 8'hFD
`define RSU_GRP_RRC       5'h01
`define RSU_GRP_RR        5'h03
`define RSU_GRP_SLA       5'h04
`define RSU_GRP_SRA       5'h05
`define RSU_OP_RR_MEM     8'h1E
`define RSU_OP_SRA_MEM    8'h2E
// ----------------------------------------
// Register field codes
// ----------------------------------------
`define RSU_R_B    3'h0
`define RSU_R_C    3'h1
`define RSU_R_D    3'h2
`define RSU_R_E    3'h3
`define RSU_R_H    3'h4
`define RSU_R_L    3'h5
`define RSU_R_MEM  3'h6
`define RSU_R_A    3'h7
// ----------------------------------------
// Flag bit positions in the flag byte
// ----------------------------------------
`define RSU_F_C  0
`define RSU_F_N  1
`define RSU_F_PV 2
`define RSU_F_H  4
`define RSU_F_Z  6
`define RSU_F_S  7
// ----------------------------------------
// Timing in clock states and machine cycles
// ----------------------------------------
`define RSU_T_REG  5'h08
`define RSU_T_PTR  5'h0F
`define RSU_T_IDX  5'h17
`define RSU_M_REG  3'h2
`define RSU_M_PTR  3'h4
`define RSU_M_IDX  3'h6
// States of a form that lie outside the counted wait
`define RSU_T_PIPE 5'h03
`endif

// ==== rtl/rsu_unit.v ====
// Rotate and shift unit: decode, timing, datapath and write back
//
// Functional notes
// - rotate circular right, bit0 to carry and bit7
// - rotate right through carry, carry into bit7
// - shift left, old bit7 into carry
// - shift right, bit7 kept, bit0 to carry
// - sign flag copies result bit 7
// - zero flag on zero result, H and N cleared
// - parity flag set on even ones count
// - register, pointer or two indexed operand forms
// - register field codes B..L, A=111, 110 memory
// - CB prefix; DD/FD CB disp op indexed
// - shift right pattern 00101 rrr, memory 2E
// - 8, 15 or 23 states per form
//
// The placing of the registers and the plain strobed port were decided locally.
`include "rsu_consts.vh"
module rsu_unit
(
  input  wire        ref_clk,
  input  wire        nrst,
  input  wire        state_en,
  input  wire        fetch_valid,
  input  wire [7:0]  fetch_byte,
  input  wire [7:0]  reg_rd_data,
  input  wire [7:0]  flags_in,
  input  wire [15:0] pointer_pair,
  input  wire [15:0] first_index_reg,
  input  wire [15:0] second_index_reg,
  input  wire [7:0]  mem_rd_data,
  output wire [2:0]  reg_sel,
  output reg         reg_wr,
  output reg  [7:0]  reg_wr_data,
  output reg         flags_wr,
  output reg  [7:0]  flags_out,
  output reg  [15:0] mem_addr,
  output reg         mem_rd,
  output reg         mem_wr,
  output reg  [7:0]  mem_wr_data,
  output wire        busy,
  output reg         done,
  output reg         illegal,
  output reg  [2:0]  m_cycles,
  output reg  [4:0]  t_states
);

// ----------------------------------------
// Interface timing
// ----------------------------------------
// reg_sel follows the captured op byte; the register file answers
// in the same cycle, since reg_rd_data is latched in OP
// mem_rd stands one cycle and mem_rd_data is taken at its end,
// so memory must answer combinationally; a registered memory
// would need an extra read state here
// reg_wr or mem_wr, flags_wr and done pulse together, once
// t_states holds the last form's figure until the next write back;
// m_cycles is reloaded in OP, even when the op then aborts
// illegal pulses once on an abort; the unit is idle again in the
// next cycle and takes a fresh prefix there
// Decode steps do not wait on state_en; only the wait does, so a
// slowed core stretches the tail of an instruction, not its head

// ----------------------------------------
// States
// ----------------------------------------
localparam ST_IDLE = 3'h0;
localparam ST_CB   = 3'h1;
localparam ST_IXCB = 3'h2;
localparam ST_DISP = 3'h3;
localparam ST_OP   = 3'h4;
localparam ST_READ = 3'h5;
localparam ST_WAIT = 3'h6;
localparam ST_EXEC = 3'h7;

// Flow, one clock per state once its byte is offered, unless noted:
//   IDLE  takes the bare prefix or an index prefix
//   IXCB  wants the second prefix, anything else aborts
//   DISP  keeps the displacement byte
//   CB    keeps the operation byte
//   OP    checks the op, latches a register or starts a read
//   READ  samples the memory byte under the read strobe
//   WAIT  spends state pulses until the form's count is met
//   EXEC  writes result and flags back, pulses done
// An abort returns to IDLE without any write back
// Bytes offered from OP to EXEC are dropped, so the decoder
// must hold the next instruction until done

reg  [2:0]  st_reg;
reg  [2:0]  st_next;
reg         idx_reg;
reg         which_ix_reg;
reg  [7:0]  disp_reg;
reg  [7:0]  op_reg;
reg  [7:0]  operand_reg;
reg  [4:0]  tcnt_reg;
reg  [4:0]  ttarget_reg;
reg  [15:0] addr_reg;

wire [2:0]  op_field = op_reg[2:0];
wire [4:0]  op_group = op_reg[7:3];
wire        op_mem   = (op_field == `RSU_R_MEM);
wire        carry_in = flags_in[`RSU_F_C];
wire        grp_ok   = (op_group == `RSU_GRP_RRC) ||
                       (op_group == `RSU_GRP_RR)  ||
                       (op_group == `RSU_GRP_SLA) ||
                       (op_group == `RSU_GRP_SRA);

// ----------------------------------------
// Datapath
// ----------------------------------------
reg  [7:0]  result;
reg         carry_out;
reg  [7:0]  flags_next;

// One shift or rotate per group; unknown groups never reach write back
always @*
begin
  result    = operand_reg;
  carry_out = carry_in;
  case (op_group)
    `RSU_GRP_RRC:
    begin
      result    = {operand_reg[0], operand_reg[7:1]};
      carry_out = operand_reg[0];
    end
    `RSU_GRP_RR:
    begin
      result    = {carry_in, operand_reg[7:1]};
      carry_out = operand_reg[0];
    end
    `RSU_GRP_SLA:
    begin
      result    = {operand_reg[6:0], 1'b0};
      carry_out = operand_reg[7];
    end
    `RSU_GRP_SRA:
    begin
      result    = {operand_reg[7], operand_reg[7:1]};
      carry_out = operand_reg[0];
    end
    default:
    begin
      result    = operand_reg;
      carry_out = carry_in;
    end
  endcase
end

// Flag byte; bits 3 and 5 pass through untouched
always @*
begin
  flags_next              = flags_in;
  flags_next[`RSU_F_S]    = result[7];
  flags_next[`RSU_F_Z]    = (result == 8'h00);
  flags_next[`RSU_F_H]    = 1'b0;
  flags_next[`RSU_F_N]    = 1'b0;
  flags_next[`RSU_F_PV]   = ~(^result);
  flags_next[`RSU_F_C]    = carry_out;
end

// ----------------------------------------
// State count
// ----------------------------------------
// The prefix state, the state that leaves the wait and the exec
// state lie outside the count, so the wait ends three states short
// and the whole instruction spans exactly the form's states
wire [4:0]  wait_limit = ttarget_reg - `RSU_T_PIPE;
wire        wait_over  = state_en && (tcnt_reg >= wait_limit);

// Cleared on each first byte, so every form counts from its own
// prefix; frozen between state pulses
always @(posedge ref_clk)
begin
  if (!nrst)
    tcnt_reg <= 5'h00;
  else if (st_reg == ST_IDLE)
  begin
    if (fetch_valid)
      tcnt_reg <= 5'h00;
  end
  else if (state_en)
    tcnt_reg <= tcnt_reg + 5'h01;
end

// ----------------------------------------
// Decode sequencer
// ----------------------------------------
// Register field comes straight from the op byte, so the file reads early
assign reg_sel = op_field;
assign busy    = (st_reg != ST_IDLE);

// Indexed address uses the sign-extended displacement
wire [15:0] idx_base = which_ix_reg ? second_index_reg : first_index_reg;
wire [15:0] idx_addr = idx_base + {{8{disp_reg[7]}}, disp_reg};

// Next state; prefix bytes gate which byte is expected next
always @*
begin
  st_next = st_reg;
  case (st_reg)
    ST_IDLE:
      if (fetch_valid && fetch_byte == `RSU_PFX_CB)
        st_next = ST_CB;
      else if (fetch_valid && (fetch_byte == `RSU_PFX_FIRST_IX ||
                               fetch_byte == `RSU_PFX_SECOND_IX))
        st_next = ST_IXCB;
    ST_CB:
      if (fetch_valid)
        st_next = ST_OP;
    ST_IXCB:
      if (fetch_valid)
        st_next = (fetch_byte == `RSU_PFX_CB) ? ST_DISP : ST_IDLE;
    ST_DISP:
      if (fetch_valid)
        st_next = ST_CB;
    // Bad group, or a register field on an indexed form, aborts
    ST_OP:
      if (!grp_ok || (idx_reg && !op_mem))
        st_next = ST_IDLE;
      else
        st_next = op_mem ? ST_READ : ST_WAIT;
    ST_READ:
      st_next = ST_WAIT;
    ST_WAIT:
      if (wait_over)
        st_next = ST_EXEC;
    ST_EXEC:
      st_next = ST_IDLE;
    default:
      st_next = ST_IDLE;
  endcase
end

// ----------------------------------------
// Sequencer registers and outputs
// ----------------------------------------
// State-count runs on the state enable so timing scales with the core
always @(posedge ref_clk)
begin
  if (!nrst)
  begin
    // Everything idle, every strobe quiet
    st_reg       <= ST_IDLE;
    idx_reg      <= 1'b0;
    which_ix_reg <= 1'b0;
    disp_reg     <= 8'h00;
    op_reg       <= 8'h00;
    operand_reg  <= 8'h00;
    ttarget_reg  <= 5'h00;
    addr_reg     <= 16'h0000;
    reg_wr       <= 1'b0;
    reg_wr_data  <= 8'h00;
    flags_wr     <= 1'b0;
    flags_out    <= 8'h00;
    mem_addr     <= 16'h0000;
    mem_rd       <= 1'b0;
    mem_wr       <= 1'b0;
    mem_wr_data  <= 8'h00;
    done         <= 1'b0;
    illegal      <= 1'b0;
    m_cycles     <= 3'h0;
    t_states     <= 5'h00;
  end
  else
  begin
    st_reg   <= st_next;
    // Strobes drop back low unless a state raises them
    reg_wr   <= 1'b0;
    flags_wr <= 1'b0;
    mem_rd   <= 1'b0;
    mem_wr   <= 1'b0;
    done     <= 1'b0;
    illegal  <= 1'b0;
    // Per-state captures and the write back
    case (st_reg)
      ST_IDLE:
        if (fetch_valid)
        begin
          idx_reg      <= (fetch_byte != `RSU_PFX_CB);
          which_ix_reg <= (fetch_byte == `RSU_PFX_SECOND_IX);
        end
      ST_IXCB:
        if (fetch_valid && fetch_byte != `RSU_PFX_CB)
          illegal <= 1'b1;
      ST_DISP:
        if (fetch_valid)
          disp_reg <= fetch_byte;
      ST_CB:
        if (fetch_valid)
          op_reg <= fetch_byte;
      ST_OP:
      begin
        if (!grp_ok || (idx_reg && !op_mem))
          illegal <= 1'b1;
        // Operand source and write target chosen once here
        addr_reg <= idx_reg ? idx_addr : pointer_pair;
        mem_addr <= idx_reg ? idx_addr : pointer_pair;
        mem_rd   <= op_mem;
        if (!op_mem)
          operand_reg <= reg_rd_data;
        if (idx_reg)
        begin
          ttarget_reg <= `RSU_T_IDX;
          m_cycles    <= `RSU_M_IDX;
        end
        else if (op_mem)
        begin
          ttarget_reg <= `RSU_T_PTR;
          m_cycles    <= `RSU_M_PTR;
        end
        else
        begin
          ttarget_reg <= `RSU_T_REG;
          m_cycles    <= `RSU_M_REG;
        end
      end
      // Memory answers while the read strobe stands
      ST_READ:
        operand_reg <= mem_rd_data;
      // Write back goes where the operand came from
      ST_EXEC:
      begin
        flags_wr  <= 1'b1;
        flags_out <= flags_next;
        done      <= 1'b1;
        t_states  <= ttarget_reg;
        if (op_mem)
        begin
          mem_addr    <= addr_reg;
          mem_wr      <= 1'b1;
          mem_wr_data <= result;
        end
        else
        begin
          reg_wr      <= 1'b1;
          reg_wr_data <= result;
        end
      end
      default:
        illegal <= 1'b0;
    endcase
  end
end

endmodule

// ==== tb/rsu_far_model.sv ====
// Register file, flag register and memory facing the unit
module rsu_far_model
(
  input  wire        ref_clk,
  input  wire [2:0]  reg_sel,
  input  wire        reg_wr,
  input  wire [7:0]  reg_wr_data,
  input  wire        flags_wr,
  input  wire [7:0]  flags_out,
  input  wire [15:0] mem_addr,
  input  wire        mem_rd,
  input  wire        mem_wr,
  input  wire [7:0]  mem_wr_data,
  output wire [7:0]  reg_rd_data,
  output logic [7:0] flags_in,
  output wire [7:0]  mem_rd_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] rf [0:7];
  logic [7:0] mem [0:65535];
  // Register file read has no delay
  assign reg_rd_data = rf[reg_sel];
  // Memory answers while the read strobe stands, inverted junk otherwise
  assign mem_rd_data = mem_rd ? mem[mem_addr] : ~mem[mem_addr];
  // Register, memory and flag writes
  always @(posedge ref_clk)
  begin
    if (reg_wr) rf[reg_sel] <= reg_wr_data;
    if (mem_wr) mem[mem_addr] <= mem_wr_data;
    if (flags_wr) flags_in <= flags_out;
  end
endmodule

// ==== tb/rsu_unit_bench.sv ====
// Self-checking bench for the rotate and shift unit
`include "rsu_consts.vh"
module rsu_unit_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk, nrst, fetch_valid, state_en;
  logic [7:0]  fetch_byte;
  logic [15:0] pointer_pair, first_index_reg, second_index_reg;
  wire  [7:0]  reg_rd_data, flags_in, mem_rd_data, reg_wr_data, flags_out;
  wire  [7:0]  mem_wr_data;
  wire  [2:0]  reg_sel, m_cycles;
  wire  [15:0] mem_addr;
  wire  [4:0]  t_states;
  wire         reg_wr, flags_wr, mem_rd, mem_wr, busy, done, illegal;
  int          n_fail, cmp_count;
  logic        got_done, got_ill;
  logic [4:0]  got_t;
  logic [7:0]  got_cyc;
  logic [4:0]  grp [0:3] = '{`RSU_GRP_RRC, `RSU_GRP_RR, `RSU_GRP_SLA,
                              `RSU_GRP_SRA};
  logic [7:0]  vals [0:6] = '{8'h31, 8'hDD, 8'hB1, 8'h01, 8'h80, 8'h00, 8'hB8};
  // Unit under test; state_en high gives one processor state per clock
  rsu_unit u_dut (.ref_clk, .nrst, .state_en, .fetch_valid, .fetch_byte,
    .reg_rd_data, .flags_in, .pointer_pair, .first_index_reg,
    .second_index_reg, .mem_rd_data, .reg_sel, .reg_wr, .reg_wr_data,
    .flags_wr, .flags_out, .mem_addr, .mem_rd, .mem_wr, .mem_wr_data, .busy,
    .done, .illegal, .m_cycles, .t_states);
  rsu_far_model u_far (.ref_clk, .reg_sel, .reg_wr, .reg_wr_data, .flags_wr,
    .flags_out, .mem_addr, .mem_rd, .mem_wr, .mem_wr_data, .reg_rd_data,
    .flags_in, .mem_rd_data);
  // ----
  // Tasks
  // ----
  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e)
    begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      n_fail++;
    end
  endtask
  // Bytes back to back, then wait bounded for completion or abort
  task run(input int n, input logic [7:0] b0, b1, b2, b3);
    logic [7:0] b [0:3];
    b = '{b0, b1, b2, b3};
    got_done = 0;
    got_ill = 0;
    for (int i = 0; i < n + 40 && !got_done && !got_ill; i++)
    begin
      fetch_valid <= (i < n);
      fetch_byte <= b[i % 4];
      @(posedge ref_clk);
      got_done = done;
      got_ill = illegal;
      got_t = t_states;
      got_cyc = i[7:0];
    end
    fetch_valid <= 1'b0;
    @(posedge ref_clk);
  endtask
  function automatic logic [8:0] ref_op(int g, logic [7:0] v, logic c);
    case (g)
      0: return {v[0], v[0], v[7:1]};
      1: return {v[0], c, v[7:1]};
      2: return {v[7], v[6:0], 1'b0};
      default: return {v[0], v[7], v[7:1]};
    endcase
  endfunction
  // Form f: 0 register, 1 pointer, 2 first index, 3 second index
  task one(input int g, input int f, input logic [2:0] rc,
           input logic [7:0] v, input logic c);
    logic [7:0]  op;
    logic [8:0]  e;
    logic [15:0] a;
    op = {grp[g], (f == 0) ? rc : `RSU_R_MEM};
    a = (f == 1) ? 16'h4343 : (f == 2) ? 16'h1000 : 16'h207F;
    e = ref_op(g, v, c);
    u_far.flags_in = {7'h1F, c};
    if (f == 0) u_far.rf[rc] = v;
    else u_far.mem[a] = v;
    if (f < 2) run(2, `RSU_PFX_CB, op, 0, 0);
    else run(4, f == 2 ? 8'hDD : 8'hFD, 8'hCB, f == 2 ? 8'hFD : 8'h7F, op);
    chk("done", 1, got_done);
    chk("result", e[7:0], f == 0 ? u_far.rf[rc] : u_far.mem[a]);
    chk("flags", {e[7], e[7:0] == 0, 3'h5, ~^e[7:0], 1'b0, e[8]}, u_far.flags_in);
    chk("states", f == 0 ? 8 : f == 1 ? 15 : 23, got_t);
    chk("cycles", f == 0 ? 8 : f == 1 ? 15 : 23, got_cyc);
    chk("mcycles", f == 0 ? 2 : f == 1 ? 4 : 6, m_cycles);
  endtask
  task print_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // ----
  // Clock, watchdog and sequence
  // ----
  initial
  begin
    ref_clk = 0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  initial
  begin
    repeat (5000) @(posedge ref_clk);
    n_fail++;
    print_verdict;
  end
  initial
  begin
    nrst = 0;
    fetch_valid = 0;
    state_en = 1'b1;
    fetch_byte = 0;
    pointer_pair = 16'h4343;
    first_index_reg = 16'h1003;
    second_index_reg = 16'h2000;
    repeat (12) @(posedge ref_clk);
    nrst <= 1'b1;
    @(posedge ref_clk);
    // Each register code with the operations in turn
    for (int k = 0; k < 7; k++)
      one(k % 4, 0, (k == 6) ? `RSU_R_A : k[2:0], vals[k], k[0]);
    // No state pulses: the write back must wait for them
    state_en <= 1'b0;
    u_far.rf[0] = 8'h31;
    u_far.flags_in = 8'h00;
    run(2, `RSU_PFX_CB, 8'h08, 0, 0);
    chk("stall done", 0, got_done);
    state_en <= 1'b1;
    run(0, 0, 0, 0, 0);
    chk("stall done", 1, got_done);
    chk("stall result", 8'h98, u_far.rf[0]);
    // Memory forms, negative displacement on the first index
    for (int g = 0; g < 4; g++)
      for (int f = 1; f < 4; f++)
        one(g, f, `RSU_R_MEM, vals[g + f], f[1]);
    run(2, 8'hDD, 8'h00, 0, 0);
    chk("illegal", 1, got_ill);
    run(4, 8'hFD, 8'hCB, 8'h05, 8'h0F);
    chk("illegal", 1, got_ill);
    print_verdict;
  end
endmodule

// ==== tb/rsu_unit_chk.sv ====
// Assertion checker for the rotate and shift unit
module rsu_unit_chk
(
  input wire        ref_clk,
  input wire        nrst,
  input wire        state_en,
  input wire        busy,
  input wire        reg_wr,
  input wire [7:0]  reg_wr_data,
  input wire        flags_wr,
  input wire [7:0]  flags_out,
  input wire [15:0] mem_addr,
  input wire        mem_rd,
  input wire        mem_wr,
  input wire [7:0]  mem_wr_data,
  input wire        done,
  input wire        illegal,
  input wire [2:0]  m_cycles,
  input wire [4:0]  t_states
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] rd_addr_reg;
  logic [4:0]  span_cnt_reg;
  wire  [7:0]  res;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  // Result of whichever write back is active
  assign res = reg_wr ? reg_wr_data : mem_wr_data;
  // Operand address, so the write back can be tied to it
  always @(posedge ref_clk)
    if (mem_rd) rd_addr_reg <= mem_addr;
  // State pulses seen while busy, to time the whole instruction
  always @(posedge ref_clk)
    if (!nrst || !busy) span_cnt_reg <= 5'h00;
    else if (state_en) span_cnt_reg <= span_cnt_reg + 5'h01;
  // ----
  // Write back steps
  // ----
  sequence s_wb_reg;
    reg_wr && flags_wr && done;
  endsequence
  sequence s_wb_mem;
    mem_wr && flags_wr && done;
  endsequence
  AST_RD_THEN_WR: assert property (mem_rd |-> ##[2:30] s_wb_mem)
    else $error("memory read not followed by write back");
  AST_WB_ADDR: assert property (mem_wr |-> mem_addr == rd_addr_reg)
    else $error("write back address differs from read");
  AST_WB_ONE: assert property (done |-> s_wb_reg or s_wb_mem)
    else $error("done without a matching write back");
  AST_T_REG: assert property (s_wb_reg |-> t_states == 5'h08 && m_cycles == 3'h2)
    else $error("register form timing wrong");
  AST_T_MEM: assert property (s_wb_mem |-> (t_states == 5'h0F && m_cycles == 3'h4)
    || (t_states == 5'h17 && m_cycles == 3'h6))
    else $error("memory form timing wrong");
  AST_STATE_SPAN: assert property (done |-> span_cnt_reg + 5'h01 == t_states)
    else $error("instruction length differs from its state count");
  AST_SIGN: assert property (flags_wr |-> flags_out[7] == res[7])
    else $error("sign flag wrong");
  AST_ZERO: assert property (flags_wr |-> flags_out[6] == (res == 8'h00)
    && !flags_out[4] && !flags_out[1])
    else $error("zero, half carry or subtract flag wrong");
  AST_PARITY: assert property (flags_wr |-> flags_out[2] == ~^res)
    else $error("parity flag wrong");
  AST_ILL_ABORT: assert property (illegal |-> (!done) [*3])
    else $error("aborted sequence completed");
endmodule
bind rsu_unit rsu_unit_chk u_chk (.ref_clk, .nrst, .state_en, .busy,
  .reg_wr, .reg_wr_data,
  .flags_wr, .flags_out, .mem_addr, .mem_rd, .mem_wr, .mem_wr_data, .done,
  .illegal, .m_cycles, .t_states);
